/* fx_ctrl_pkg.sv */
// Shared constants, types and register layout for the effects preset controller
package fx_ctrl_pkg;

	// ==================================================================
	// Preset selector
	localparam int          PRESETS_DEF    = 16;
	localparam int          PRESET_W       = 5;
	localparam int          LED_W          = 16;

	// ==================================================================
	// MIDI program change
	localparam logic [3:0]  PC_STATUS_HI   = 4'hc;
	localparam logic [3:0]  RX_CHANNEL     = 4'h0;
	localparam logic [7:0]  REALTIME_MIN   = 8'hf8;
	localparam logic [6:0]  BYPASS_ON_VAL  = 7'h65;
	localparam logic [6:0]  BYPASS_OFF_VAL = 7'h64;

	// ==================================================================
	// Register map, byte addresses
	localparam int          REG_AW         = 4;
	localparam logic [3:0]  CTRL_OFS       = 4'h0;
	localparam logic [3:0]  STATUS_OFS     = 4'h4;
	localparam int          CTRL_MIDI_EN   = 0;
	localparam int          CTRL_STEP      = 1;
	localparam logic        MIDI_EN_RST    = 1'b1;
	localparam int          ST_PRESET_LSB  = 0;
	localparam int          ST_BYPASS      = 8;
	localparam int          ST_MUTE        = 9;
	localparam int          ST_FOOT        = 10;
	localparam int          ST_DISABLED    = 11;
	localparam int          ST_RESTORED    = 12;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	// ==================================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
	} midi_byte_t;

	typedef struct packed {
		logic        valid;
		logic [6:0]  data;
	} pc_evt_t;

	typedef struct packed {
		logic [PRESET_W-1:0] preset;
		logic                bypass;
	} nv_rec_t;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic                int_mute;
		logic                ext_mute;
		logic                mute_led;
		logic                ret_mute;
		logic                fx_disable;
		logic [LED_W-1:0]    leds;
	} fx_out_t;

	typedef enum logic {PS_IDLE, PS_DATA} parse_st_t;

endpackage : fx_ctrl_pkg

/* midi_pc_parser.sv */
// MIDI program change parser for the fixed receive channel
module midi_pc_parser (
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  wire fx_ctrl_pkg::midi_byte_t byte_i,
	output fx_ctrl_pkg::pc_evt_t     pc_o
);
	import fx_ctrl_pkg::*;

	typedef struct packed {
		parse_st_t st;
		pc_evt_t   pc;
	} parse_state_t;

	parse_state_t s_r;
	parse_state_t s_nxt;

	// ==================================================================
	// Parser
	always_comb begin
		s_nxt          = s_r;
		s_nxt.pc.valid = 1'b0;
		if (byte_i.valid) begin
			// Realtime bytes may interleave anywhere and leave status intact
			if (byte_i.data >= REALTIME_MIN) begin
				s_nxt.st = s_r.st;
			end else if (byte_i.data[7]) begin
				if (byte_i.data == {PC_STATUS_HI, RX_CHANNEL}) begin
					s_nxt.st = PS_DATA;
				end else begin
					s_nxt.st = PS_IDLE;
				end
			end else if (s_r.st == PS_DATA) begin
				// Running status: stay armed for further data bytes
				s_nxt.pc.valid = 1'b1;
				s_nxt.pc.data  = byte_i.data[6:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '{st: PS_IDLE, pc: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pc_o = s_r.pc;

	// ==================================================================
	// Checks
	property p_pc_form;
		@(posedge clk_i) disable iff (!rst_b_i)
		(byte_i.valid && byte_i.data == 8'hc0) ##1 (byte_i.valid && !byte_i.data[7])
		|=> (pc_o.valid && pc_o.data == $past(byte_i.data[6:0]));
	endproperty
	a_pc_form: assert property (p_pc_form) else $error("Program change not decoded");

	property p_pc_chan;
		@(posedge clk_i) disable iff (!rst_b_i)
		(byte_i.valid && byte_i.data[7] && byte_i.data < 8'hf8 && byte_i.data != 8'hc0)
		##1 (byte_i.valid && !byte_i.data[7]) |=> !pc_o.valid;
	endproperty
	a_pc_chan: assert property (p_pc_chan) else $error("Foreign message accepted");

endmodule // midi_pc_parser

/* fx_preset_ctrl.sv */
// Effects preset selector, MIDI bypass, mute combining and register slave
// Overview of operation
// - Step button advances preset, wraps via disabled
// - Seventeen states, one LED each or none
// - Last preset saved and restored at power-up
// - Last MIDI bypass saved and restored likewise
// - Footswitch closed holds effects muted
// - Footswitch mutes internal and external returns
// - Engaged mute button makes footswitch irrelevant
// - Mute LED lights for button or footswitch
// - Only MIDI channel one is obeyed
// - Program change status plus one data byte
// - Data 65H bypass on, 64H off
// - Data 00H-0FH select presets one to sixteen
module fx_preset_ctrl #(
	parameter int NUM_PRESETS = fx_ctrl_pkg::PRESETS_DEF
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_b_i,
	input  wire logic                   sel_btn_i,
	input  wire logic                   mute_btn_i,
	input  wire logic                   foot_i,
	input  wire fx_ctrl_pkg::midi_byte_t midi_i,
	input  wire fx_ctrl_pkg::nv_rec_t   nv_i,
	output fx_ctrl_pkg::nv_rec_t        nv_save_o,
	output logic                        nv_save_stb_o,
	output fx_ctrl_pkg::fx_out_t        fx_o,
	input  wire fx_ctrl_pkg::axil_req_t axi_i,
	output fx_ctrl_pkg::axil_rsp_t      axi_o
);
	import fx_ctrl_pkg::*;

	if (NUM_PRESETS < 1 || NUM_PRESETS > LED_W) begin : g_bad_presets
		$error("NUM_PRESETS must lie in 1..16");
	end

	localparam logic [PRESET_W-1:0] DIS_CODE = PRESET_W'(NUM_PRESETS);

	typedef struct packed {
		logic [PRESET_W-1:0] preset;
		logic                bypass;
		logic                restored;
		logic                sel_q;
		logic                midi_en;
		nv_rec_t             save;
		logic                save_stb;
		fx_out_t             out;
		logic                aw_got;
		logic                w_got;
		logic [REG_AW-1:0]   awaddr;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		axil_rsp_t           rsp;
	} core_state_t;

	core_state_t s_r;
	core_state_t s_nxt;
	pc_evt_t     pc;

	// ==================================================================
	// Helpers
	function automatic logic [LED_W-1:0] led_decode(input logic [PRESET_W-1:0] p);
		logic [LED_W-1:0] v;
		v = '0;
		if (p < DIS_CODE) begin
			v[p[3:0]] = 1'b1;
		end
		return v;
	endfunction

	function automatic logic [PRESET_W-1:0] clamp_preset(input logic [PRESET_W-1:0] p);
		// Corrupt storage falls back to the disabled state, never a stray LED
		return (p > DIS_CODE) ? DIS_CODE : p;
	endfunction

	function automatic logic [PRESET_W-1:0] step_preset(input logic [PRESET_W-1:0] p);
		return (p >= DIS_CODE) ? '0 : PRESET_W'(p + 1'b1);
	endfunction

	// ==================================================================
	// MIDI front end
	midi_pc_parser u_parser (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.byte_i  (midi_i),
		.pc_o    (pc)
	);

	logic midi_act;
	logic midi_sel;
	logic btn_step;
	assign midi_act = pc.valid && s_r.midi_en && s_r.restored;
	assign midi_sel = midi_act && (pc.data < 7'(NUM_PRESETS));
	assign btn_step = sel_btn_i && !s_r.sel_q;

	// ==================================================================
	// Next state
	always_comb begin
		logic           sw_step;
		logic           wr_fire;
		logic           mute;
		logic [31:0]    status;
		sw_step         = 1'b0;
		wr_fire         = 1'b0;
		mute            = 1'b0;
		status          = '0;
		s_nxt           = s_r;
		s_nxt.save_stb  = 1'b0;
		s_nxt.sel_q     = sel_btn_i;

		// Register slave, write side
		if (axi_i.awvalid && s_r.rsp.awready) begin
			s_nxt.aw_got      = 1'b1;
			s_nxt.awaddr      = axi_i.awaddr[REG_AW-1:0];
			s_nxt.rsp.awready = 1'b0;
		end
		if (axi_i.wvalid && s_r.rsp.wready) begin
			s_nxt.w_got      = 1'b1;
			s_nxt.wdata      = axi_i.wdata;
			s_nxt.wstrb      = axi_i.wstrb;
			s_nxt.rsp.wready = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.rsp.bvalid) begin
			wr_fire          = 1'b1;
			s_nxt.aw_got     = 1'b0;
			s_nxt.w_got      = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp  = RESP_SLVERR;
			if (s_r.awaddr == CTRL_OFS) begin
				s_nxt.rsp.bresp = RESP_OKAY;
				if (s_r.wstrb[0]) begin
					s_nxt.midi_en = s_r.wdata[CTRL_MIDI_EN];
					sw_step       = s_r.wdata[CTRL_STEP];
				end
			end else if (s_r.awaddr == STATUS_OFS) begin
				// Status is read-only; the write is accepted and dropped
				s_nxt.rsp.bresp = RESP_OKAY;
			end
		end
		if (s_r.rsp.bvalid && axi_i.bready) begin
			s_nxt.rsp.bvalid  = 1'b0;
			s_nxt.rsp.awready = 1'b1;
			s_nxt.rsp.wready  = 1'b1;
		end

		// Preset and bypass
		if (!s_r.restored) begin
			s_nxt.restored = 1'b1;
			s_nxt.preset   = clamp_preset(nv_i.preset);
			s_nxt.bypass   = nv_i.bypass;
		end else begin
			if (midi_act) begin
				if (midi_sel) begin
					s_nxt.preset = pc.data[PRESET_W-1:0];
				end else if (pc.data == BYPASS_ON_VAL) begin
					s_nxt.bypass = 1'b1;
				end else if (pc.data == BYPASS_OFF_VAL) begin
					s_nxt.bypass = 1'b0;
				end
			end
			// MIDI selection wins over a simultaneous button step
			if (!midi_sel && (btn_step || (wr_fire && sw_step))) begin
				s_nxt.preset = step_preset(s_r.preset);
			end
			if (s_nxt.preset != s_r.preset || s_nxt.bypass != s_r.bypass) begin
				s_nxt.save_stb = 1'b1;
				s_nxt.save     = '{preset: s_nxt.preset, bypass: s_nxt.bypass};
			end
		end

		// Mute combining; OR makes the footswitch moot while the button holds
		mute                 = mute_btn_i || foot_i;
		s_nxt.out.int_mute   = mute;
		s_nxt.out.ext_mute   = mute;
		s_nxt.out.mute_led   = mute;
		s_nxt.out.fx_disable = (s_nxt.preset == DIS_CODE);
		s_nxt.out.leds       = led_decode(s_nxt.preset);
		s_nxt.out.ret_mute   = mute || s_nxt.bypass || (s_nxt.preset == DIS_CODE);

		// Register slave, read side
		status[ST_PRESET_LSB +: PRESET_W] = s_r.preset;
		status[ST_BYPASS]                 = s_r.bypass;
		status[ST_MUTE]                   = s_r.out.mute_led;
		status[ST_FOOT]                   = foot_i;
		status[ST_DISABLED]               = s_r.out.fx_disable;
		status[ST_RESTORED]               = s_r.restored;
		if (axi_i.arvalid && s_r.rsp.arready) begin
			s_nxt.rsp.arready = 1'b0;
			s_nxt.rsp.rvalid  = 1'b1;
			s_nxt.rsp.rresp   = RESP_OKAY;
			s_nxt.rsp.rdata   = '0;
			if (axi_i.araddr[REG_AW-1:0] == CTRL_OFS) begin
				s_nxt.rsp.rdata[CTRL_MIDI_EN] = s_r.midi_en;
			end else if (axi_i.araddr[REG_AW-1:0] == STATUS_OFS) begin
				s_nxt.rsp.rdata = status;
			end else begin
				s_nxt.rsp.rresp = RESP_SLVERR;
			end
		end
		if (s_r.rsp.rvalid && axi_i.rready) begin
			s_nxt.rsp.rvalid  = 1'b0;
			s_nxt.rsp.arready = 1'b1;
		end
	end

	// ==================================================================
	// State register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r             <= '0;
			s_r.midi_en     <= MIDI_EN_RST;
			s_r.rsp.awready <= 1'b1;
			s_r.rsp.wready  <= 1'b1;
			s_r.rsp.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign fx_o          = s_r.out;
	assign axi_o         = s_r.rsp;
	assign nv_save_o     = s_r.save;
	assign nv_save_stb_o = s_r.save_stb;

	// ==================================================================
	// Checks
	property p_step;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_r.restored && btn_step && !midi_sel)
		|=> (s_r.preset == (($past(s_r.preset) >= DIS_CODE) ? 5'h00 : $past(s_r.preset) + 5'h01));
	endproperty
	a_step: assert property (p_step) else $error("Button step wrong");

	property p_leds;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_r.restored |-> (fx_o.leds == led_decode(s_r.preset))
			&& (fx_o.fx_disable == (s_r.preset == DIS_CODE))
			&& (s_r.preset <= DIS_CODE);
	endproperty
	a_leds: assert property (p_leds) else $error("Preset LEDs mismatch");

	property p_restore;
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(s_r.restored) |-> (s_r.preset == clamp_preset($past(nv_i.preset)))
			&& (s_r.bypass == $past(nv_i.bypass));
	endproperty
	a_restore: assert property (p_restore) else $error("Power-up restore wrong");

	property p_save;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_r.restored && $past(s_r.restored) && $changed(s_r.preset))
		|-> nv_save_stb_o && nv_save_o.preset == s_r.preset && nv_save_o.bypass == s_r.bypass;
	endproperty
	a_save: assert property (p_save) else $error("Preset change not saved");

	property p_foot;
		@(posedge clk_i) disable iff (!rst_b_i)
		foot_i [*2] |=> fx_o.int_mute && fx_o.ext_mute && fx_o.mute_led && fx_o.ret_mute;
	endproperty
	a_foot: assert property (p_foot) else $error("Footswitch not muting");

	property p_both;
		@(posedge clk_i) disable iff (!rst_b_i)
		fx_o.int_mute == fx_o.ext_mute;
	endproperty
	a_both: assert property (p_both) else $error("Returns muted apart");

	property p_btn;
		@(posedge clk_i) disable iff (!rst_b_i)
		(mute_btn_i && $changed(foot_i)) |=> fx_o.int_mute && fx_o.mute_led;
	endproperty
	a_btn: assert property (p_btn) else $error("Footswitch overrode button");

	property p_led;
		@(posedge clk_i) disable iff (!rst_b_i)
		##1 fx_o.mute_led == ($past(mute_btn_i) || $past(foot_i));
	endproperty
	a_led: assert property (p_led) else $error("Mute LED wrong");

	property p_bypass;
		@(posedge clk_i) disable iff (!rst_b_i)
		(midi_act && (pc.data == 7'h65 || pc.data == 7'h64))
		|=> s_r.bypass == ($past(pc.data) == 7'h65);
	endproperty
	a_bypass: assert property (p_bypass) else $error("MIDI bypass wrong");

	property p_select;
		@(posedge clk_i) disable iff (!rst_b_i)
		midi_sel |=> s_r.preset == $past(pc.data[4:0]);
	endproperty
	a_select: assert property (p_select) else $error("MIDI preset wrong");

	property p_ignore;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_r.restored && pc.valid && !midi_sel && !btn_step && !(s_r.aw_got && s_r.w_got)
			&& pc.data != 7'h65 && pc.data != 7'h64) |=> $stable(s_r.preset) && $stable(s_r.bypass);
	endproperty
	a_ignore: assert property (p_ignore) else $error("Ignored value changed state");

	property p_ret;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_r.restored |-> fx_o.ret_mute == (fx_o.mute_led || s_r.bypass || fx_o.fx_disable);
	endproperty
	a_ret: assert property (p_ret) else $error("Return mute wrong");

	property p_wrap;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_r.restored && btn_step && !midi_sel && s_r.preset == DIS_CODE)
		|=> (s_r.preset == '0) && fx_o.leds[0] && !fx_o.fx_disable;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Wrap after disabled wrong");

	property p_one_led;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_r.restored && !fx_o.fx_disable) |-> $onehot(fx_o.leds);
	endproperty
	a_one_led: assert property (p_one_led) else $error("Preset LED not one-hot");

	property p_dis_dark;
		@(posedge clk_i) disable iff (!rst_b_i)
		fx_o.fx_disable |-> (fx_o.leds == '0);
	endproperty
	a_dis_dark: assert property (p_dis_dark) else $error("LED lit while disabled");

	property p_restore_quiet;
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(s_r.restored) |-> !nv_save_stb_o;
	endproperty
	a_restore_quiet: assert property (p_restore_quiet) else $error("Restore caused a save");

	property p_byp_save;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_r.restored && $past(s_r.restored) && $changed(s_r.bypass))
		|-> nv_save_stb_o && nv_save_o.bypass == s_r.bypass;
	endproperty
	a_byp_save: assert property (p_byp_save) else $error("Bypass change not saved");

	property p_mute_ret;
		@(posedge clk_i) disable iff (!rst_b_i)
		fx_o.int_mute |-> fx_o.ret_mute;
	endproperty
	a_mute_ret: assert property (p_mute_ret) else $error("Muted return not silenced");

endmodule // fx_preset_ctrl

/* midi_src.sv */
// Behavioural MIDI sender standing in for a sequencer or keyboard
module midi_src (
	input  wire logic             clk_i,
	output fx_ctrl_pkg::midi_byte_t midi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import fx_ctrl_pkg::*;
	initial begin
		midi_o = '0;
	end
	// ==========
	// Byte and message tasks
	// Idle data inverted so a stale byte never reads as fresh
	// Zero gap keeps valid high so the next byte follows back to back
	task automatic send(input logic [7:0] b, input int gap);
		@(posedge clk_i);
		midi_o <= {1'b1, b};
		if (gap > 0) begin
			@(posedge clk_i);
			midi_o <= {1'b0, ~b};
			repeat (gap - 1) @(posedge clk_i);
		end
	endtask
	task automatic pc(input logic [3:0] ch, input logic [6:0] v, input int gap);
		send({PC_STATUS_HI, ch}, gap);
		send({1'b0, v}, gap + 1);
	endtask
endmodule // midi_src

/* test_fx_preset_ctrl.sv */
// Self-checking bench for the effects preset controller
module test_fx_preset_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import fx_ctrl_pkg::*;
	logic       clk_i = 1'b0;
	logic       rst_b_i = 1'b0;
	logic       sel_btn_i = 1'b0;
	logic       mute_btn_i = 1'b0;
	logic       foot_i = 1'b0;
	midi_byte_t midi;
	nv_rec_t    nv_i = {5'd3, 1'b1};
	nv_rec_t    nv_save;
	logic       nv_stb;
	fx_out_t    fx;
	axil_req_t  req = '0;
	axil_rsp_t  rsp;
	int         err_count = 0;
	int         checked = 0;
	int         saves = 0;
	int         cyc = 0;
	// Channel in high nibble, data below: all must be ignored
	logic [10:0] ign [6] = '{11'h010, 11'h063, 11'h066, 11'h07f, 11'h102, 11'h782};

	always #2.5 clk_i = ~clk_i;

	fx_preset_ctrl #(.NUM_PRESETS(16)) i_dut (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.sel_btn_i(sel_btn_i),
		.mute_btn_i(mute_btn_i),
		.foot_i(foot_i),
		.midi_i(midi),
		.nv_i(nv_i),
		.nv_save_o(nv_save),
		.nv_save_stb_o(nv_stb),
		.fx_o(fx),
		.axi_i(req),
		.axi_o(rsp)
	);
	midi_src i_midi (
		.clk_i(clk_i),
		.midi_o(midi)
	);

	// ==========
	// Save pulse counter and timeout
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (nv_stb === 1'b1) saves <= saves + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("[FAIL] %0t timeout", $time);
			summarize();
		end
	end

	// ==========
	// Helpers
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string m);
		chk({30'h0, g}, {30'h0, e}, m);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		settle();
	endtask
	task automatic press();
		@(posedge clk_i);
		sel_btn_i <= 1'b1;
		@(posedge clk_i);
		sel_btn_i <= 1'b0;
		settle();
	endtask
	task automatic drive(input logic m, input logic f);
		@(posedge clk_i);
		mute_btn_i <= m;
		foot_i <= f;
		settle();
	endtask
	task automatic leds(input int p, input string m);
		chk({16'h0, fx.leds}, (p < 16) ? (32'h1 << p) : 32'h0, m);
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		req.awvalid <= 1'b1;
		req.awaddr <= {28'h0, a};
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		while (n < 100) begin
			@(posedge clk_i);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) begin
				req.bready <= 1'b0;
				chk_resp(rsp.bresp, er, "bresp");
				n = 1000;
			end
		end
		if (n != 1000) chk(32'h1, 32'h0, "write hang");
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		req.arvalid <= 1'b1;
		req.araddr <= {28'h0, a};
		req.rready <= 1'b1;
		while (n < 100) begin
			@(posedge clk_i);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				req.rready <= 1'b0;
				chk(rsp.rdata, ed, "rdata");
				chk_resp(rsp.rresp, er, "rresp");
				n = 1000;
			end
		end
		if (n != 1000) chk(32'h1, 32'h0, "read hang");
	endtask

	// ==========
	// Tests
	initial begin
		do_reset();
		leds(3, "restore");
		chk(32'(fx.ret_mute), 32'h1, "restore byp");
		chk(saves, 0, "restore save");
		axi_rd(STATUS_OFS, 32'h1103, RESP_OKAY);
		i_midi.pc(RX_CHANNEL, BYPASS_OFF_VAL, 0);
		settle();
		chk(32'(fx.ret_mute), 32'h0, "byp off");
		chk(32'(nv_save.bypass), 32'h0, "save byp");
		$display("test restore done");
		for (int p = 4; p <= 16; p++) begin
			press();
			leds(p, "step");
			chk(32'(fx.fx_disable), 32'(p == 16), "disable");
		end
		chk(32'(fx.ret_mute), 32'h1, "dis ret");
		press();
		leds(0, "wrap");
		chk(saves, 15, "saves");
		$display("test step done");
		for (int v = 0; v < 16; v++) begin
			i_midi.pc(RX_CHANNEL, 7'(v), v % 2);
			settle();
			leds(v, "pc");
			chk(32'(nv_save.preset), 32'(v), "save pre");
		end
		i_midi.send(8'hc0, 0);
		i_midi.send(REALTIME_MIN, 0);
		i_midi.send(8'h05, 1);
		settle();
		leds(5, "realtime");
		i_midi.send(8'h07, 1);
		settle();
		leds(7, "running");
		foreach (ign[i]) i_midi.pc(ign[i][10:7], ign[i][6:0], 0);
		settle();
		leds(7, "ignored");
		chk(32'(fx.ret_mute), 32'h0, "ign byp");
		i_midi.pc(RX_CHANNEL, BYPASS_ON_VAL, 0);
		settle();
		chk({28'h0, fx.int_mute, fx.mute_led, fx.ret_mute, 1'b0}, 32'h2, "byp on");
		i_midi.pc(RX_CHANNEL, BYPASS_OFF_VAL, 0);
		$display("test midi done");
		drive(1'b0, 1'b1);
		chk({fx.int_mute, fx.ext_mute, fx.mute_led, fx.ret_mute}, 32'hf, "foot");
		drive(1'b0, 1'b0);
		chk({fx.int_mute, fx.ext_mute, fx.mute_led, fx.ret_mute}, 32'h0, "foot off");
		drive(1'b1, 1'b0);
		chk(32'(fx.mute_led), 32'h1, "btn led");
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
		chk({fx.int_mute, fx.ext_mute}, 32'h3, "btn held");
		drive(1'b0, 1'b0);
		$display("test mute done");
		axi_wr(CTRL_OFS, 32'h3, RESP_OKAY);
		settle();
		leds(8, "reg step");
		axi_rd(CTRL_OFS, 32'h1, RESP_OKAY);
		axi_wr(4'h8, 32'h0, RESP_SLVERR);
		axi_rd(4'hc, 32'h0, RESP_SLVERR);
		axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
		i_midi.pc(RX_CHANNEL, 7'h2, 0);
		settle();
		leds(8, "midi off");
		$display("test regs done");
		@(posedge clk_i);
		nv_i <= {5'd20, 1'b0};
		do_reset();
		chk({fx.fx_disable, fx.leds}, 32'h10000, "bad nv");
		$display("test bad record done");
		summarize();
	end
endmodule // test_fx_preset_ctrl
